/* File: hdl/apea_pkg.sv */
package apea_pkg;
   // Sample and datapath widths
   localparam int SAMPLE_W = 20;
   localparam int PROD_W = 40;
   localparam int GAIN_W = 12;
   localparam int SCALED_W = 42;
   localparam int OFFSET_W = 8;
   localparam int ACTIVE_W = 26;
   localparam int WAVE_W = 24;
   localparam int ACC_W = 40;
   localparam int STATUS_W = 5;
   localparam int MODE_W = 16;
   localparam int IRQ_EN_W = 8;

   // Gain of one plus trim over 4096
   localparam int GAIN_FRAC = 12;
   localparam logic signed [13:0] GAIN_UNITY = 14'sh1000;
   // Low-pass filter pole and output scaling
   localparam int LPF_SHIFT = 10;
   localparam int ACTIVE_SHIFT = 16;
   // Offset trim has two bits below the waveform sample LSB
   localparam int OFFSET_FRAC = 2;

   // Accumulation period in master clocks
   localparam int ACC_PERIOD = 4;
   localparam logic [1:0] ACC_PERIOD_LAST = 2'(ACC_PERIOD - 1);
   // Fastest waveform rate: one sample per 128 clocks
   localparam int WAVE_BASE_DIV = 128;
   localparam int WAVE_CNT_W = 10;

   // Mode word fields
   localparam int MODE_RATE_LSB = 11;
   localparam int MODE_SRC_LSB = 13;
   localparam logic [1:0] SRC_ACTIVE_POWER = 2'h0;

   // Interrupt enable word fields
   localparam int IEN_HALF_POS = 0;
   localparam int IEN_HALF_NEG = 1;
   localparam int IEN_OVERFLOW = 2;
   localparam int IEN_UNDERFLOW = 3;
   localparam int IEN_WAVE_SAMPLE = 4;
   localparam int IEN_WAVE_SELECT = 5;

   // Status bit positions match the first enable bits
   localparam int ST_HALF_POS = 0;
   localparam int ST_HALF_NEG = 1;
   localparam int ST_OVERFLOW = 2;
   localparam int ST_UNDERFLOW = 3;
   localparam int ST_WAVE_READY = 4;

   localparam logic [ACC_W-1:0] ACC_RESET = 40'h00_0000_0000;
   localparam logic [STATUS_W-1:0] STATUS_RESET = 5'h00;

   typedef struct packed {
      logic [GAIN_W-1:0] power_gain_trim;
      logic [OFFSET_W-1:0] power_offset_trim;
      logic [MODE_W-1:0] mode;
      logic [IRQ_EN_W-1:0] irq_enable;
   } apea_cfg_type;
endpackage : apea_pkg

/* File: hdl/apea_accumulator.sv */
// How it works
// (RULE1) Power sample is current sample times matching voltage sample.
// (RULE2) Low-pass filter extracts dc of product as the active power.
// (RULE3) Power range scales with gain trim, least at 800h, most at 7FFh.
// (RULE4) Active power accumulates nonstop into a 40-bit energy register.
// (RULE5) Energy register takes one active power value every four clocks.
// (RULE6) Accumulation is signed; negative power lowers the energy.
// (RULE7) Source field 0,0 with waveform select puts power in sample register.
// (RULE8) Waveform rate selectable: fastest, half, quarter or eighth.
// (RULE9) Positive overflow wraps to most negative and keeps climbing.
// (RULE10) Negative underflow wraps to most positive and keeps falling.
// (RULE11) Enabled half-full or over/underflow events pull irq_n low.
// (RULE12) Signed 8-bit offset trim zeroes active power at no load.
// (RULE13) Four offset trim steps equal one waveform sample step.
// (RULE14) Gain trim is 12-bit signed, factor one plus trim over 4096.
// (RULE15) Mode bits 12:11 pick the waveform sample rate.
// (RULE16) Each new waveform sample pulls irq_n low when enabled.
// (RULE17) Offset is added after the filter, before accumulator and samples.
`timescale 1ns/1ps
`default_nettype none
module apea_accumulator
   import apea_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sample_valid,
   input wire logic signed [SAMPLE_W-1:0] current_sample,
   input wire logic signed [SAMPLE_W-1:0] voltage_sample,
   input wire apea_cfg_type cfg,
   input wire logic [STATUS_W-1:0] status_clear,
   output logic signed [ACC_W-1:0] energy_accumulator,
   output logic signed [WAVE_W-1:0] waveform_sample,
   output logic [STATUS_W-1:0] status,
   output logic irq_n
);
   logic signed [PROD_W-1:0] prod_q;
   logic signed [SCALED_W-1:0] scaled_q;
   logic signed [SCALED_W-1:0] lpf_q;
   logic signed [ACTIVE_W-1:0] active_q;
   logic signed [WAVE_W-1:0] active_wave;
   logic signed [ACC_W-1:0] acc_q;
   logic signed [ACC_W-1:0] acc_d;
   logic [1:0] acc_cnt_q;
   logic acc_step;
   logic [WAVE_CNT_W-1:0] wave_cnt_q;
   logic [WAVE_CNT_W-1:0] wave_last;
   logic wave_tick;
   logic wave_on;
   logic signed [WAVE_W-1:0] wave_q;
   logic [STATUS_W-1:0] status_q;
   logic [STATUS_W-1:0] events;
   logic irq_n_q;
   logic signed [13:0] gain_factor;
   logic signed [55:0] gain_prod;
   logic signed [SCALED_W-1:0] lpf_err;
   logic signed [ACTIVE_W-1:0] offset_ext;
   logic [1:0] top_before;
   logic [1:0] top_after;
   logic addend_neg;
   logic [STATUS_W-1:0] irq_pending;

   // Half-full crossing: bit below the sign flips inside one sign half
   function automatic logic half_cross(
      input logic [1:0] old_top,
      input logic [1:0] new_top,
      input logic neg
   );
      return (old_top == {neg, neg}) && (new_top == {neg, !neg});
   endfunction : half_cross

   // Sign leaving the addend's own half means the register wrapped
   function automatic logic wrapped(
      input logic old_sign,
      input logic new_sign,
      input logic neg
   );
      return (old_sign == neg) && (new_sign != neg);
   endfunction : wrapped

   // Product of the channel pair, taken per incoming sample
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prod_q <= '0;
      end else if (sample_valid) begin
         prod_q <= PROD_W'(current_sample)
            * PROD_W'(voltage_sample); // [RULE1]
      end
   end

   // Gain factor 4096 + trim, then drop the 12 fraction bits
   assign gain_factor = GAIN_UNITY + 14'(signed'(cfg.power_gain_trim));
   assign gain_prod = 56'(prod_q) * 56'(gain_factor); // [RULE14] [RULE3]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scaled_q <= '0;
      end else begin
         scaled_q <= SCALED_W'(gain_prod >>> GAIN_FRAC); // [RULE3]
      end
   end

   // Single-pole low-pass: keeps the dc part of the product
   assign lpf_err = (scaled_q - lpf_q) >>> LPF_SHIFT;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lpf_q <= '0;
      end else begin
         lpf_q <= lpf_q + lpf_err; // [RULE2]
      end
   end

   // Offset trim lines up with the two fraction bits of active power
   assign offset_ext = ACTIVE_W'(signed'(cfg.power_offset_trim)); // [RULE12]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         active_q <= '0;
      end else begin
         // [RULE17] [RULE13]
         active_q <= ACTIVE_W'(lpf_q >>> ACTIVE_SHIFT) + offset_ext;
      end
   end

   assign active_wave = WAVE_W'(active_q >>> OFFSET_FRAC); // [RULE13]

   // Accumulation strobe every four clocks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_cnt_q <= '0;
      end else begin
         acc_cnt_q <= acc_step ? 2'h0 : acc_cnt_q + 2'h1; // [RULE5]
      end
   end

   assign acc_step = (acc_cnt_q == ACC_PERIOD_LAST);

   // Signed add, modulo 2^40 so it wraps both ways
   assign acc_d = acc_q + ACC_W'(active_wave); // [RULE6] [RULE9] [RULE10]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= ACC_RESET;
      end else if (acc_step) begin
         acc_q <= acc_d; // [RULE4] [RULE5]
      end
   end

   // Waveform sample timer, base period shifted by the rate field
   assign wave_last = WAVE_CNT_W'((WAVE_BASE_DIV
      << cfg.mode[MODE_RATE_LSB +: 2]) - 1); // [RULE8] [RULE15]
   assign wave_tick = (wave_cnt_q >= wave_last);
   assign wave_on = (cfg.mode[MODE_SRC_LSB +: 2] == SRC_ACTIVE_POWER)
      && cfg.irq_enable[IEN_WAVE_SELECT]; // [RULE7]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wave_cnt_q <= '0;
      end else begin
         wave_cnt_q <= wave_tick ? '0 : wave_cnt_q + WAVE_CNT_W'(1); // [RULE8]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wave_q <= '0;
      end else if (wave_tick && wave_on) begin
         wave_q <= active_wave; // [RULE7]
      end
   end

   // Top two bits before and after the step, and the addend's sign
   assign top_before = acc_q[ACC_W-1 -: 2];
   assign top_after = acc_d[ACC_W-1 -: 2];
   assign addend_neg = active_wave[WAVE_W-1];

   // Events: half-full crossings and wraps on accumulate steps, sample ready on each wave tick while wave_on
   always_comb begin
      events = '0;
      if (acc_step) begin
         events[ST_HALF_POS] = half_cross(top_before, top_after, 1'b0);
         events[ST_HALF_NEG] = half_cross(top_before, top_after, 1'b1);
         events[ST_OVERFLOW] = !addend_neg
            && wrapped(top_before[1], top_after[1], 1'b0); // [RULE9]
         events[ST_UNDERFLOW] = addend_neg
            && wrapped(top_before[1], top_after[1], 1'b1); // [RULE10]
      end
      events[ST_WAVE_READY] = wave_tick && wave_on; // [RULE16]
   end

   // One sticky flag per bit; a new event wins over a same-cycle clear
   for (genvar i = 0; i < STATUS_W; i++) begin : g_status
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            status_q[i] <= STATUS_RESET[i];
         end else if (events[i]) begin
            status_q[i] <= 1'b1;
         end else if (status_clear[i]) begin
            status_q[i] <= 1'b0;
         end
      end
   end

   // Flags that are both set and enabled hold the interrupt
   assign irq_pending = status_q & cfg.irq_enable[STATUS_W-1:0];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_n_q <= 1'b1;
      end else begin
         // [RULE11] [RULE16]
         irq_n_q <= !(|irq_pending);
      end
   end

   assign energy_accumulator = acc_q;
   assign waveform_sample = wave_q;
   assign status = status_q;
   assign irq_n = irq_n_q;
endmodule : apea_accumulator
`default_nettype wire

/* File: testbench/apea_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module apea_host_model
   import apea_pkg::*;
(
   input wire logic clk,
   input wire logic irq_n,
   input wire logic auto_ack,
   input wire logic [STATUS_W-1:0] status,
   input wire logic signed [WAVE_W-1:0] waveform_sample,
   output logic [STATUS_W-1:0] status_clear,
   output logic signed [WAVE_W-1:0] last_sample
);
   initial status_clear = '0;
   initial last_sample = '0;
   // Acknowledge whatever is pending once irq_n is seen low
   always @(posedge clk) begin
      #1;
      status_clear = (auto_ack && irq_n === 1'b0) ? status : '0;
      if (status_clear[ST_WAVE_READY])
         last_sample = waveform_sample;
   end
endmodule : apea_host_model
`default_nettype wire

/* File: testbench/apea_accumulator_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module apea_accumulator_sva
   import apea_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire apea_cfg_type cfg,
   input wire logic [STATUS_W-1:0] status_clear,
   input wire logic signed [ACC_W-1:0] energy_accumulator,
   input wire logic signed [WAVE_W-1:0] waveform_sample,
   input wire logic [STATUS_W-1:0] status,
   input wire logic irq_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic [ACC_W-1:0] e = energy_accumulator;
   logic want_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         want_q <= 1'b0;
      else
         want_q <= |(status & cfg.irq_enable[STATUS_W-1:0]);
   end
   sequence s_step; $changed(e); endsequence
   sequence s_hold; $stable(e) [*3]; endsequence
   AST_PERIOD: assert property (s_step |=> s_hold)
      else $error("energy changed inside period");
   AST_IRQ: assert property (irq_n == !want_q)
      else $error("irq_n disagrees with status");
   AST_WSRC: assert property ($changed(waveform_sample) |->
      $past(cfg.mode[MODE_SRC_LSB+:2]) == SRC_ACTIVE_POWER &&
      $past(cfg.irq_enable[IEN_WAVE_SELECT]))
      else $error("sample taken in wrong mode");
   AST_WRDY: assert property ($changed(waveform_sample) |->
      status[ST_WAVE_READY]) else $error("sample without ready");
   AST_OVF: assert property (!$past(e[39]) && $past(e[38]) && e[39] |->
      status[ST_OVERFLOW]) else $error("overflow not flagged");
   AST_UNF: assert property ($past(e[39]) && !$past(e[38]) && !e[39] |->
      status[ST_UNDERFLOW]) else $error("underflow not flagged");
   AST_HPOS: assert property (!$past(e[39]) && !e[39]
      && $rose(e[38]) |-> status[ST_HALF_POS])
      else $error("half positive not flagged");
   AST_HNEG: assert property ($past(e[39]) && e[39]
      && $fell(e[38]) |-> status[ST_HALF_NEG])
      else $error("half negative not flagged");
   AST_STICKY: assert property ($fell(status[ST_WAVE_READY]) |->
      $past(status_clear[ST_WAVE_READY])) else $error("ready lost");
endmodule : apea_accumulator_sva
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import apea_pkg::*;
;
   logic clk = 0, rst_n = 0, sample_valid = 0, auto_ack = 0, irq_n;
   logic signed [SAMPLE_W-1:0] cur = '0, volt = '0;
   apea_cfg_type cfg = '0;
   logic [STATUS_W-1:0] clr, status;
   logic signed [ACC_W-1:0] energy, e0, d;
   logic signed [WAVE_W-1:0] wave, last;
   logic signed [7:0] offs [4] = '{8'sh10, 8'shf0, 8'sh7f, 8'sh80};
   logic [GAIN_W-1:0] gains [3] = '{12'h800, 12'h000, 12'h7ff};
   int gexp [3] = '{32, 64, 95};
   int errors = 0, n_tests = 0, cycles = 0, t0;
   apea_accumulator u_apea_accumulator (.clk(clk), .rst_n(rst_n),
      .sample_valid(sample_valid), .current_sample(cur),
      .voltage_sample(volt), .cfg(cfg), .status_clear(clr),
      .energy_accumulator(energy), .waveform_sample(wave),
      .status(status), .irq_n(irq_n));
   apea_host_model u_apea_host_model (.clk(clk), .irq_n(irq_n),
      .auto_ack(auto_ack), .status(status), .waveform_sample(wave),
      .status_clear(clr), .last_sample(last));
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         conclude();
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic check(input string name, input logic [ACC_W-1:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic irq_fall();
      while (irq_n !== 1'b1) cyc(1);
      while (irq_n !== 1'b0) cyc(1);
   endtask : irq_fall
   task automatic conclude();
      if (errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude
   initial begin
      cfg.irq_enable[IEN_WAVE_SELECT] = 1'b1;
      cyc(10);
      rst_n = 1'b1;
      // Zero samples: only the offset trim reaches the energy
      foreach (offs[i]) begin
         cfg.power_offset_trim = offs[i];
         d = offs[i] >>> 2;
         cyc(20);
         e0 = energy;
         cyc(400);
         check("energy", energy - e0, d * 100);
         check("wave", ACC_W'(wave), d);
      end
      auto_ack = 1'b1;
      cfg.irq_enable[IEN_WAVE_SAMPLE] = 1'b1;
      for (int r = 0; r < 4; r++) begin
         cfg.mode[MODE_RATE_LSB+:2] = 2'(r);
         irq_fall();
         irq_fall();
         t0 = cycles;
         irq_fall();
         check("period", ACC_W'(cycles - t0), ACC_W'(128 << r));
      end
      check("host", ACC_W'(last), d);
      auto_ack = 1'b0;
      cfg.irq_enable[IEN_WAVE_SAMPLE] = 1'b0;
      cyc(1100);
      check("ready", ACC_W'(status[ST_WAVE_READY]), 40'h1);
      check("masked", ACC_W'(irq_n), 40'h1);
      cfg.irq_enable[IEN_WAVE_SAMPLE] = 1'b1;
      cyc(2);
      check("irq", ACC_W'(irq_n), 40'h0);
      cfg.mode[MODE_SRC_LSB+:2] = 2'h1;
      auto_ack = 1'b1;
      cyc(1100);
      check("no_sample", ACC_W'(status[ST_WAVE_READY]), 40'h0);
      cfg.mode[MODE_SRC_LSB+:2] = SRC_ACTIVE_POWER;
      cfg.power_offset_trim = 8'h00;
      cur = 20'sh01000;
      volt = 20'sh01000;
      sample_valid = 1'b1;
      cyc(1);
      sample_valid = 1'b0;
      foreach (gains[i]) begin
         cfg.power_gain_trim = gains[i];
         cyc(6000);
         d = wave - gexp[i];
         check("gain", ACC_W'(d * d <= 4), 40'h1);
      end
      conclude();
   end
endmodule : tb_top
bind apea_accumulator apea_accumulator_sva u_apea_accumulator_sva (
   .clk(clk), .rst_n(rst_n), .cfg(cfg), .status_clear(status_clear),
   .energy_accumulator(energy_accumulator),
   .waveform_sample(waveform_sample), .status(status), .irq_n(irq_n));
`default_nettype wire
